// ---- core/fpes_consts.svh ----
`ifndef FPES_CONSTS_SVH
`define FPES_CONSTS_SVH
// unlock key codes, accepted only in this order
`define FPES_KEY_CODE1 8'ha5
`define FPES_KEY_CODE2 8'hf1
`define FPES_ERASED_WORD 16'hffff
`define FPES_ERASED_BYTE 8'hff
// 512-byte pages: page offset is the low 9 address bits
`define FPES_PAGE_LSB 9
`define FPES_PAGE_OFS 9'h000
// timing
`define FPES_CLK_PERIOD_NS 40
`define FPES_PROG_TIME_NS 10000
`define FPES_ERASE_TIME_NS 20000000
`define FPES_PROG_CYCLES ((`FPES_PROG_TIME_NS + `FPES_CLK_PERIOD_NS - 1) / `FPES_CLK_PERIOD_NS)
`define FPES_ERASE_CYCLES ((`FPES_ERASE_TIME_NS + `FPES_CLK_PERIOD_NS - 1) / `FPES_CLK_PERIOD_NS)
// register word indices (byte address bits 3:2)
`define FPES_REG_CTRL 2'h0
`define FPES_REG_KEY 2'h1
`define FPES_REG_STAT 2'h2
// control register bits
`define FPES_CTRL_WEN 0
`define FPES_CTRL_EEN 1
`define FPES_CTRL_BLK 2
`define FPES_CTRL_RTS 3
`define FPES_CTRL_W 4
`define FPES_CTRL_RST 4'h0
// axi responses
`define FPES_RESP_OKAY 2'b00
`define FPES_RESP_SLVERR 2'b10
`endif

// ---- core/fpes_op_timer.sv ----
`timescale 1ns/100ps
// down counter that times one flash operation
module fpes_op_timer #(
    parameter int unsigned CNT_W = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [CNT_W-1:0] len,
    output logic done
);
    logic [CNT_W-1:0] cnt_r;
    logic run_r;
    logic last;

    // done marks the final cycle of a run of len cycles
    assign last = run_r && (cnt_r == CNT_W'(1));
    assign done = last;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else if (start) begin
            cnt_r <= len;
            run_r <= 1'b1;
        end else if (run_r) begin
            cnt_r <= cnt_r - CNT_W'(1);
            run_r <= !last;
        end
    end
endmodule : fpes_op_timer

// ---- core/fpes_pkg.sv ----
package fpes_pkg;
    // unlock progress
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_OPEN = 2'b10,
        KEY_BLOCKED = 2'b11
    } fpes_key_t;
    // flash operation sequencing
    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_READ = 2'b01,
        OP_PROG = 2'b10,
        OP_ERASE = 2'b11
    } fpes_op_t;
    // a byte write from the core or the debug port
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } fpes_wbyte_t;
    // command to the flash array
    typedef struct packed {
        logic prog;
        logic erase;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [1:0] bmask;
    } fpes_flash_cmd_t;
endpackage : fpes_pkg

// ---- core/fpes_sequencer.sv ----
`timescale 1ns/100ps
`include "fpes_consts.svh"
// Functional notes
// - programming only clears bits; new data is ANDed with current contents
// - writes and erases are timed here; core stalls until done
// - core flash operations need key 0xA5 then 0xF1 first; debug port needs none
// - any interval between the two key writes is accepted
// - wrong or misordered key code blocks flash operations until reset
// - flash attempt before key completion blocks operations until reset
// - every core operation returns the unlock state to locked; debug operations leave it alone
// - write enable steers core writes to flash; stays until cleared
// - erase enable plus write enable: write erases whole 512-byte page
// - block select chooses single-byte or aligned two-byte programming
// - block program lasts as long as a single-byte program
// - single-byte mode: one program per core write to flash
// - block mode: even byte buffered, program after odd write
// - debug port and core writes both program flash
// - page erase ignores the written data byte
// - attempt with supply monitor off raises flash error reset
module fpes_sequencer #(
    parameter int unsigned ERASE_CYCLES = `FPES_ERASE_CYCLES,
    parameter int unsigned CNT_W = 20
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic XMOVE_WR,
    input wire fpes_pkg::fpes_wbyte_t XMOVE,
    input wire logic DBG_REQ,
    input wire logic DBG_ERASE,
    input wire fpes_pkg::fpes_wbyte_t DBG,
    input wire logic VDD_MON_EN,
    input wire logic [15:0] FL_RDATA,
    output logic XRAM_WE,
    output fpes_pkg::fpes_wbyte_t XRAM,
    output logic CORE_STALL,
    output fpes_pkg::fpes_flash_cmd_t FL_CMD,
    output logic FLASH_ERR_RST
);
    import fpes_pkg::*;

    localparam logic [CNT_W-1:0] PROG_LEN = CNT_W'(`FPES_PROG_CYCLES);
    localparam logic [CNT_W-1:0] ERASE_LEN = CNT_W'(ERASE_CYCLES);
    localparam int PROG_N = `FPES_PROG_CYCLES;

    // ---- axi4-lite slave ----
    logic aw_full_r, w_full_r, bvalid_r, rvalid_r, awready_r, wready_r, arready_r;
    logic [1:0] aw_idx_r, bresp_r, rresp_r;
    logic [7:0] w_byte_r;
    logic w_lane0_r;
    logic [31:0] rdata_r;
    logic aw_take, w_take, ar_take, wr_do;
    logic aw_full_nxt, w_full_nxt, bvalid_nxt, rvalid_nxt;

    // address and data may come in either order; act when both are held
    assign aw_take = S_AXI_AWVALID && awready_r;
    assign w_take = S_AXI_WVALID && wready_r;
    assign ar_take = S_AXI_ARVALID && arready_r;
    assign wr_do = aw_full_r && w_full_r && !bvalid_r;
    assign aw_full_nxt = (aw_full_r || aw_take) && !wr_do;
    assign w_full_nxt = (w_full_r || w_take) && !wr_do;
    assign bvalid_nxt = wr_do || (bvalid_r && !S_AXI_BREADY);
    assign rvalid_nxt = ar_take || (rvalid_r && !S_AXI_RREADY);

    // control register and decode
    logic [`FPES_CTRL_W-1:0] ctrl_r;
    logic hit_ctrl, hit_key, hit_stat, wr_ok, ctrl_wr, key_wr;
    logic [1:0] ar_idx;
    logic ar_ok;
    assign hit_ctrl = aw_idx_r == `FPES_REG_CTRL;
    assign hit_key = aw_idx_r == `FPES_REG_KEY;
    assign hit_stat = aw_idx_r == `FPES_REG_STAT;
    assign wr_ok = hit_ctrl || hit_key || hit_stat;
    assign ctrl_wr = wr_do && hit_ctrl && w_lane0_r;
    assign key_wr = wr_do && hit_key && w_lane0_r;
    assign ar_idx = S_AXI_ARADDR[3:2];
    assign ar_ok = ar_idx != 2'h3;

    logic wen, een, blk;
    assign wen = ctrl_r[`FPES_CTRL_WEN];
    assign een = ctrl_r[`FPES_CTRL_EEN];
    assign blk = ctrl_r[`FPES_CTRL_BLK];

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            arready_r <= 1'b0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            bvalid_r <= bvalid_nxt;
            rvalid_r <= rvalid_nxt;
            awready_r <= !aw_full_nxt;
            wready_r <= !w_full_nxt;
            arready_r <= !rvalid_nxt;
        end
    end

    // payload capture; the register bits live in lane 0 only
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            aw_idx_r <= 2'h0;
            w_byte_r <= 8'h00;
            w_lane0_r <= 1'b0;
            bresp_r <= `FPES_RESP_OKAY;
        end else begin
            if (aw_take) aw_idx_r <= S_AXI_AWADDR[3:2];
            if (w_take) w_byte_r <= S_AXI_WDATA[7:0];
            if (w_take) w_lane0_r <= S_AXI_WSTRB[0];
            if (wr_do) bresp_r <= wr_ok ? `FPES_RESP_OKAY : `FPES_RESP_SLVERR;
        end
    end

    // write enable stays set until software clears it
    always_ff @(posedge MCLK) begin
        if (SYS_RST) ctrl_r <= `FPES_CTRL_RST;
        else if (ctrl_wr) ctrl_r <= w_byte_r[`FPES_CTRL_W-1:0];
    end

    // ---- unlock key and operation control ----
    fpes_key_t key_r, key_nxt;
    fpes_op_t op_r, op_nxt;
    logic [7:0] even_r;
    logic pend_r;
    logic try_fl, vdd_bad, key_ok, go_erase, go_even, go_prog, dbg_go, start_any;
    logic tmr_done, tmr_start;
    logic [CNT_W-1:0] tmr_len;

    // a core write while write enable is set targets flash, not ram
    assign try_fl = XMOVE_WR && wen && op_r == OP_IDLE;
    assign vdd_bad = try_fl && !VDD_MON_EN;
    assign key_ok = try_fl && VDD_MON_EN && key_r == KEY_OPEN;
    assign go_erase = key_ok && een;
    assign go_even = key_ok && !een && blk && !XMOVE.addr[0];
    assign go_prog = key_ok && !een && !go_even;
    // debug programming needs no key; core writes take precedence
    assign dbg_go = DBG_REQ && op_r == OP_IDLE && !try_fl;
    assign start_any = go_erase || go_prog || dbg_go;

    // key codes: only order matters, any gap between them is fine
    always_comb begin
        key_nxt = key_r;
        if (key_wr && key_r != KEY_BLOCKED) begin
            if (key_r == KEY_IDLE && w_byte_r == `FPES_KEY_CODE1) key_nxt = KEY_HALF;
            else if (key_r == KEY_HALF && w_byte_r == `FPES_KEY_CODE2) key_nxt = KEY_OPEN;
            else key_nxt = KEY_BLOCKED;
        end
        if (try_fl && VDD_MON_EN && key_r != KEY_OPEN) key_nxt = KEY_BLOCKED;
        if (key_ok) key_nxt = KEY_IDLE;
    end

    // operation state; the read step fetches contents before programming
    always_comb begin
        op_nxt = op_r;
        case (op_r)
            OP_IDLE: begin
                if (go_erase || (dbg_go && DBG_ERASE)) op_nxt = OP_ERASE;
                else if (start_any) op_nxt = OP_READ;
            end
            OP_READ: op_nxt = OP_PROG;
            OP_PROG: if (tmr_done) op_nxt = OP_IDLE;
            OP_ERASE: if (tmr_done) op_nxt = OP_IDLE;
            default: op_nxt = OP_IDLE;
        endcase
    end

    // erase starts timing at once, program after the read step
    assign tmr_start = (op_r == OP_IDLE && op_nxt == OP_ERASE) || op_r == OP_READ;
    assign tmr_len = (op_r == OP_READ) ? PROG_LEN : ERASE_LEN;

    fpes_op_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clk(MCLK),
        .rst(SYS_RST),
        .start(tmr_start),
        .len(tmr_len),
        .done(tmr_done)
    );

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            key_r <= KEY_IDLE;
            op_r <= OP_IDLE;
        end else begin
            key_r <= key_nxt;
            op_r <= op_nxt;
        end
    end

    // even byte waits for the odd write; a lone odd byte pairs with erased
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            even_r <= `FPES_ERASED_BYTE;
            pend_r <= 1'b0;
        end else if (go_even) begin
            even_r <= XMOVE.data;
            pend_r <= 1'b1;
        end else if (start_any) begin
            even_r <= `FPES_ERASED_BYTE;
            pend_r <= 1'b0;
        end
    end

    // flash command words for each kind of start
    fpes_wbyte_t src;
    logic [15:0] word_addr, page_addr, byte_word, blk_word;
    logic [1:0] byte_mask;
    logic use_blk, use_erase;
    assign src = try_fl ? XMOVE : DBG;
    assign word_addr = {src.addr[15:1], 1'b0};
    assign page_addr = {src.addr[15:`FPES_PAGE_LSB], `FPES_PAGE_OFS};
    assign byte_word = src.addr[0] ? {src.data, `FPES_ERASED_BYTE} : {`FPES_ERASED_BYTE, src.data};
    assign byte_mask = src.addr[0] ? 2'b10 : 2'b01;
    assign blk_word = {src.data, even_r};
    assign use_blk = go_prog && blk;
    assign use_erase = go_erase || (dbg_go && DBG_ERASE);

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            FL_CMD <= '0;
        end else begin
            if (op_r == OP_IDLE && start_any) begin
                FL_CMD.erase <= use_erase;
                FL_CMD.addr <= use_erase ? page_addr : word_addr;
                // data byte is irrelevant to an erase
                FL_CMD.wdata <= use_erase ? `FPES_ERASED_WORD
                    : (use_blk ? blk_word : byte_word);
                FL_CMD.bmask <= use_blk ? 2'b11 : byte_mask;
            end else if (op_nxt == OP_IDLE) begin
                FL_CMD.erase <= 1'b0;
            end
            // cells can only be cleared, so never ask for a 0 to 1 change
            if (op_r == OP_READ) FL_CMD.wdata <= FL_CMD.wdata & FL_RDATA;
            FL_CMD.prog <= op_nxt == OP_PROG;
        end
    end

    // core outputs; ram writes pass through when flash is not selected
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            XRAM_WE <= 1'b0;
            XRAM <= '0;
            CORE_STALL <= 1'b0;
            FLASH_ERR_RST <= 1'b0;
        end else begin
            XRAM_WE <= XMOVE_WR && !wen;
            if (XMOVE_WR) XRAM <= XMOVE;
            CORE_STALL <= op_nxt != OP_IDLE;
            FLASH_ERR_RST <= vdd_bad;
        end
    end

    // read data
    logic [31:0] rd_word;
    assign rd_word = (ar_idx == `FPES_REG_CTRL) ? {28'h0, ctrl_r}
        : (ar_idx == `FPES_REG_KEY) ? {30'h0, key_r}
        : (ar_idx == `FPES_REG_STAT) ? {29'h0, pend_r, op_r != OP_IDLE, key_r == KEY_BLOCKED}
        : 32'h0;

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rdata_r <= 32'h0;
            rresp_r <= `FPES_RESP_OKAY;
        end else if (ar_take) begin
            rdata_r <= rd_word;
            rresp_r <= ar_ok ? `FPES_RESP_OKAY : `FPES_RESP_SLVERR;
        end
    end

    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = wready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;

    // ---- checks ----
    int prog_cnt;
    always_ff @(posedge MCLK) begin
        if (SYS_RST || op_r != OP_PROG) prog_cnt <= 0;
        else prog_cnt <= prog_cnt + 1;
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    a_lock_after_op: assert property (key_ok |=> key_r == KEY_IDLE)
        else $error("key not relocked after operation");
    a_block_sticky: assert property (key_r == KEY_BLOCKED |=> key_r == KEY_BLOCKED)
        else $error("blocked state released without reset");
    a_bad_code: assert property (key_wr && key_r == KEY_IDLE && w_byte_r != `FPES_KEY_CODE1
        && !try_fl |=> key_r == KEY_BLOCKED)
        else $error("wrong first code did not block");
    a_early_try: assert property (try_fl && VDD_MON_EN && key_r == KEY_HALF
        |=> key_r == KEY_BLOCKED && op_r == OP_IDLE)
        else $error("flash attempt before key was not refused");
    a_prog_length: assert property (op_r == OP_PROG && op_nxt != OP_PROG
        |-> prog_cnt == PROG_N - 1)
        else $error("program time wrong");
    a_stall_busy: assert property ($rose(CORE_STALL) |-> $past(start_any))
        else $error("stall raised without a started operation");
    a_ram_steer: assert property (XMOVE_WR |=> XRAM_WE == !$past(wen))
        else $error("core write steered wrongly");
    a_no_set_bits: assert property (op_r == OP_READ
        |=> (FL_CMD.wdata & ~$past(FL_RDATA)) == 16'h0)
        else $error("program would set a bit");
    a_erase_page: assert property (go_erase |=> FL_CMD.erase
        && FL_CMD.addr[`FPES_PAGE_LSB-1:0] == `FPES_PAGE_OFS
        && FL_CMD.wdata == `FPES_ERASED_WORD)
        else $error("erase not page aligned");
    a_even_held: assert property (go_even |=> pend_r && op_r == OP_IDLE
        && even_r == $past(XMOVE.data))
        else $error("even byte not buffered");
    a_single_go: assert property (go_prog && !blk |=> op_r == OP_READ ##1 FL_CMD.prog)
        else $error("single byte write did not program");
    a_vdd_error: assert property (vdd_bad |=> FLASH_ERR_RST && op_r == OP_IDLE)
        else $error("supply monitor error not raised");

    c_erase: cover property (go_erase ##[1:1000] op_r == OP_ERASE);
    c_block: cover property (go_even ##[1:200] go_prog);
    c_blocked: cover property (key_r == KEY_HALF ##1 key_r == KEY_BLOCKED);
endmodule : fpes_sequencer

// ---- tb/flash_program_erase_sequencer_test.sv ----
`timescale 1ns/100ps
`include "fpes_consts.svh"
// random core traffic around hand-picked corner cases
module flash_program_erase_sequencer_test;
    import fpes_pkg::*;
    localparam int ERC = 20;
    localparam logic [3:0] A_CTL = {`FPES_REG_CTRL, 2'h0};
    localparam logic [3:0] A_KEY = {`FPES_REG_KEY, 2'h0};
    localparam logic [3:0] A_STS = {`FPES_REG_STAT, 2'h0};
    localparam logic [3:0] A_BAD = 4'hc;
    localparam logic [1:0] OK = `FPES_RESP_OKAY;
    localparam logic [1:0] ERR = `FPES_RESP_SLVERR;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, xram_we, stall, ferr, xw, fe;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic xm_wr = 1'h0, dbg_req = 1'h0, dbg_erase = 1'h0, vdd = 1'h1;
    fpes_wbyte_t xm = '0, dbg = '0, xram, xr;
    fpes_flash_cmd_t cmd, cap;
    logic [15:0] fl_rdata;
    logic [7:0] sh [0:511];
    int seed = 75317, n_mismatch = 0, check_count = 0, pc, st;

    // 25 MHz, matching the 40 ns FPES_CLK_PERIOD_NS
    always #20 clk = ~clk;

    fpes_sequencer #(.ERASE_CYCLES(ERC)) u_fpes_sequencer (
        .MCLK(clk), .SYS_RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .XMOVE_WR(xm_wr), .XMOVE(xm), .DBG_REQ(dbg_req), .DBG_ERASE(dbg_erase), .DBG(dbg),
        .VDD_MON_EN(vdd), .FL_RDATA(fl_rdata), .XRAM_WE(xram_we), .XRAM(xram),
        .CORE_STALL(stall), .FL_CMD(cmd), .FLASH_ERR_RST(ferr)
    );
    fpes_flash_model u_fpes_flash_model (.clk(clk), .cmd(cmd), .rdata(fl_rdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // ready is sampled at the negedge before the edge that completes the transfer
    task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(negedge clk);
            aw_ok = aw_ok | awready;
            w_ok = w_ok | wready;
            @(posedge clk);
            if (aw_ok) awvalid <= 1'h0;
            if (w_ok) wvalid <= 1'h0;
        end
        bready <= 1'h1;
        do @(negedge clk); while (!bvalid);
        check(bresp, er);
        @(posedge clk);
        bready <= 1'h0;
    endtask : axw

    task automatic axr(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'h0;
        do @(negedge clk); while (!rvalid);
        check(rdata, {24'h0, e});
        check(rresp, er);
        @(posedge clk);
        rready <= 1'h0;
    endtask : axr

    // both key codes with a random gap between them
    task automatic key_open();
        int g;
        g = {$random(seed)} % 40;
        axw(A_KEY, `FPES_KEY_CODE1, OK);
        repeat (g) @(posedge clk);
        axw(A_KEY, `FPES_KEY_CODE2, OK);
    endtask : key_open

    // one write from the core (src 0) or debug port (src 1); counts stalled phase cycles
    task automatic op(input logic src, input logic er, input logic [15:0] a, input logic [7:0] d);
        if (src) begin
            dbg_req <= 1'h1;
            dbg_erase <= er;
            dbg <= {a, d};
        end else begin
            xm_wr <= 1'h1;
            xm <= {a, d};
        end
        @(posedge clk);
        dbg_req <= 1'h0;
        xm_wr <= 1'h0;
        @(negedge clk);
        xw = xram_we;
        xr = xram;
        fe = ferr;
        st = 0;
        pc = 0;
        while (stall && st < 1000) begin
            st++;
            if (cmd.prog || cmd.erase) begin
                pc++;
                cap = cmd;
            end
            @(negedge clk);
        end
        @(posedge clk);
    endtask : op

    // program and compare with the shadow; unwritten lane asks for 0xff
    task automatic prog(input logic src, input logic [15:0] a, input logic [7:0] d,
                        input logic [7:0] ev, input logic [7:0] od, input logic [1:0] m);
        logic [15:0] e;
        e = {od & sh[{a[8:1], 1'h1}], ev & sh[{a[8:1], 1'h0}]};
        op(src, 1'h0, a, d);
        check(pc, `FPES_PROG_CYCLES);
        check(cap.wdata, e);
        check(cap.bmask, m);
        check(cap.addr, {a[15:1], 1'h0});
        sh[{a[8:1], 1'h1}] = e[15:8];
        sh[{a[8:1], 1'h0}] = e[7:0];
    endtask : prog

    task automatic prog1(input logic src, input logic [15:0] a, input logic [7:0] d);
        prog(src, a, d, a[0] ? 8'hff : d, a[0] ? d : 8'hff, a[0] ? 2'h2 : 2'h1);
    endtask : prog1

    // main sequence
    initial begin
        logic [15:0] a;
        logic [7:0] d, d2;
        foreach (sh[i]) sh[i] = 8'hff;
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        axr(A_KEY, 8'h0, OK);
        axr(A_BAD, 8'h0, ERR);
        axw(A_BAD, 8'h0, ERR);
        axw(A_CTL, 8'h0, OK);
        a = 16'($random(seed));
        d = 8'($random(seed));
        op(1'h0, 1'h0, a, d);
        check(xw, 1'h1);
        check(xr, {a, d});
        check(st, 0);
        $display("test reset and ram steering done");
        // single bytes; the first two hit one address so bits can only clear
        axw(A_CTL, 8'h1, OK);
        for (int i = 0; i < 6; i++) begin
            if (i > 1) a = 16'($random(seed));
            d = 8'($random(seed));
            key_open();
            prog1(1'h0, a, d);
            axr(A_KEY, 8'h0, OK);
            axr(A_CTL, 8'h1, OK);
        end
        $display("test single byte done");
        // block mode: even byte waits, odd byte closes the pair
        axw(A_CTL, 8'h5, OK);
        for (int i = 0; i < 3; i++) begin
            a = 16'($random(seed)) & 16'hfffe;
            d = (i == 0) ? 8'hff : 8'($random(seed));
            d2 = 8'($random(seed));
            key_open();
            op(1'h0, 1'h0, a, d);
            check(st, 0);
            axr(A_STS, 8'h4, OK);
            key_open();
            prog(1'h0, a | 16'h1, d2, d, d2, 2'h3);
        end
        $display("test block done");
        // page erase with a don't-care data byte, then program the erased page
        axw(A_CTL, 8'h3, OK);
        key_open();
        op(1'h0, 1'h0, a, 8'($random(seed)));
        check(pc, ERC);
        check(cap.addr, {a[15:9], 9'h0});
        foreach (sh[i]) sh[i] = 8'hff;
        axw(A_CTL, 8'h1, OK);
        key_open();
        prog1(1'h0, a, d);
        // supply monitor off: error reset request and no operation
        key_open();
        vdd <= 1'h0;
        op(1'h0, 1'h0, a, d);
        check(fe, 1'h1);
        check(st, 0);
        vdd <= 1'h1;
        // the refused attempt leaves the key open, so it is spent here
        prog1(1'h0, a, d);
        $display("test erase and monitor done");
        // three ways into the blocked state, each left only through reset
        for (int k = 0; k < 3; k++) begin
            axw(A_CTL, 8'h1, OK);
            if (k == 2) begin
                axw(A_KEY, `FPES_KEY_CODE1, OK);
                op(1'h0, 1'h0, a, d);
            end else begin
                axw(A_KEY, k ? `FPES_KEY_CODE2 : `FPES_KEY_CODE1, OK);
                if (k == 0) axw(A_KEY, 8'h5a, OK);
            end
            axr(A_KEY, 8'h3, OK);
            key_open();
            op(1'h0, 1'h0, a, d);
            check(st, 0);
            rst <= 1'h1;
            repeat (6) @(posedge clk);
            rst <= 1'h0;
            @(posedge clk);
            axr(A_KEY, 8'h0, OK);
        end
        $display("test blocking done");
        // debug port needs no key and leaves the key state alone
        op(1'h1, 1'h1, a, d);
        check(pc, ERC);
        foreach (sh[i]) sh[i] = 8'hff;
        prog1(1'h1, a, d);
        axr(A_KEY, 8'h0, OK);
        axw(A_CTL, 8'h0, OK);
        $display("test debug port done");
        finish_test();
    end

    // watchdog: the sequence needs well under 12000 cycles
    initial begin
        #(40 * 60000);
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule : flash_program_erase_sequencer_test

// ---- tb/fpes_flash_model.sv ----
`timescale 1ns/100ps
// flash array stand-in: one page of words, aliased over the whole address space
module fpes_flash_model (
    input wire logic clk,
    input wire fpes_pkg::fpes_flash_cmd_t cmd,
    output logic [15:0] rdata
);
    import fpes_pkg::*;
    logic [15:0] mem [0:255];
    logic busy_q;
    // contents read back combinationally at the commanded word
    assign rdata = mem[cmd.addr[8:1]];
    // commit at the start of each phase; programming can only take ones away
    always @(posedge clk) begin
        busy_q <= cmd.prog | cmd.erase;
        if (cmd.erase && !busy_q) begin
            foreach (mem[i]) mem[i] <= 16'hffff;
        end
        if (cmd.prog && !busy_q && cmd.bmask[0]) begin
            mem[cmd.addr[8:1]][7:0] <= mem[cmd.addr[8:1]][7:0] & cmd.wdata[7:0];
        end
        if (cmd.prog && !busy_q && cmd.bmask[1]) begin
            mem[cmd.addr[8:1]][15:8] <= mem[cmd.addr[8:1]][15:8] & cmd.wdata[15:8];
        end
    end
    // a fresh part comes up erased
    initial begin
        foreach (mem[i]) mem[i] = 16'hffff;
    end
endmodule : fpes_flash_model
